// File: lsd_defs.vh
// Constants for the LED sink PWM dimmer: field codes, timing, widths.
// Assumes inclusion by bare name from the dimmer design files.
`ifndef LSD_DEFS_VH
`define LSD_DEFS_VH
`define LSD_CORE_HZ        250000000
`define LSD_TICK_HZ        2000000
`define LSD_TICK_DIV       (`LSD_CORE_HZ / `LSD_TICK_HZ)
`define LSD_PWM_BITS       6
`define LSD_SRC_PWM        2'h2
`define LSD_DIR_UP         2'h1
`define LSD_DIR_DOWN       2'h2
`define LSD_STEP_50MS_US   50000
`define LSD_STEP_25MS_US   25000
`define LSD_STEP_5MS_US    5000
`define LSD_STEP_2P5MS_US  2500
`define LSD_TICKS_PER_US   (`LSD_TICK_HZ / 1000000)
`define LSD_DUTY_RESET     8'h00
`define LSD_DUTY_MAX       8'hFF
`define LSD_NUM_SINKS      7
`define LSD_NUM_OFFSET     6
`endif

// File: lsd_dimmer.v
// Top of the LED sink PWM dimmer: tick, modulator, sink gating, offset.
// Assumes configuration inputs are synchronous and held stable by software.
`timescale 1ns/1ps
`default_nettype none
`include "lsd_defs.vh"
module lsd_dimmer
#(
  parameter integer TICK_DIV = `LSD_TICK_DIV,
  parameter integer NSINK    = `LSD_NUM_SINKS,
  parameter integer NOFS     = `LSD_NUM_OFFSET,
  parameter integer RAMP_TPU = `LSD_TICKS_PER_US,
  parameter integer RAMP_DIV = 1
)
(
  // Clock and reset
  input  wire                 I_CORE_CLK,
  input  wire                 I_RESETN,
  // Duty code and ramp control
  input  wire                 I_DUTY_WRITE,
  input  wire [7:0]           I_DUTY_WDATA,
  input  wire [1:0]           I_RAMP_DIR,
  input  wire [2:0]           I_RAMP_SPEED,
  // Per-sink configuration, sink k in slice k; offset level and invert in slice k mod 3
  input  wire [2*NSINK-1:0]   I_SINK_SOURCE_SEL,
  input  wire [8*NSINK-1:0]   I_SINK_LEVEL,
  input  wire [NOFS-1:0]      I_SINK_OFFSET_ENABLE,
  input  wire [23:0]          I_OFFSET_LEVEL,
  input  wire [2:0]           I_OFFSET_INVERT_ENABLE,
  // Status and sink drive
  output wire [7:0]           O_DUTY_CODE,
  output reg                  O_PWM,
  output reg  [1:0]           O_ANALOG_DIV,
  output reg  [NSINK-1:0]     O_SINK_ON,
  output reg  [8*NSINK-1:0]   O_SINK_DAC
);
  reg  [7:0] div_cnt;
  reg        tick;
  reg  [5:0] phase;
  reg  [5:0] on_time;
  reg  [1:0] next_div;
  wire [7:0] duty;

  ////////////////////////////////////////////////////////////////////////////
  // 2 MHz tick from the core clock
  always @(posedge I_CORE_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      div_cnt <= 8'h00;
      tick    <= 1'b0;
    end
    else
    begin
      tick    <= (div_cnt == TICK_DIV[7:0] - 8'h01);
      div_cnt <= (div_cnt == TICK_DIV[7:0] - 8'h01) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty code store and ramp
  lsd_ramp
  #(
    .TICKS_PER_US (RAMP_TPU),
    .INTERVAL_DIV (RAMP_DIV)
  )
  u_ramp
  (
    .i_clk    (I_CORE_CLK),
    .i_resetn (I_RESETN),
    .i_tick   (tick),
    .i_write  (I_DUTY_WRITE),
    .i_wdata  (I_DUTY_WDATA),
    .i_dir    (I_RAMP_DIR),
    .i_speed  (I_RAMP_SPEED),
    .o_duty   (duty)
  );
  assign O_DUTY_CODE = duty; // Live value, also mid-ramp

  ////////////////////////////////////////////////////////////////////////////
  // Range select: top bits trade digital span for analog divisor
  always @*
  begin
    if (duty[7])
    begin
      on_time  = duty[7:2];
      next_div = 2'h0;
    end
    else if (duty[6])
    begin
      on_time  = duty[6:1];
      next_div = 2'h1;
    end
    else
    begin
      on_time  = duty[5:0];
      next_div = 2'h2;
    end
  end

  // 64-tick period; code FFh still leaves one off slot, a known limitation
  always @(posedge I_CORE_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      phase        <= 6'h00;
      O_PWM        <= 1'b0;
      O_ANALOG_DIV <= 2'h0;
    end
    else if (tick)
    begin
      phase        <= phase + 6'h01;
      O_PWM        <= (phase < on_time);
      O_ANALOG_DIV <= next_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-sink gating and offset; offset k uses group k mod 3
  genvar k;
  generate
    for (k = 0; k < NSINK; k = k + 1)
    begin : g_sink
      wire       pwm_sel = (I_SINK_SOURCE_SEL[2*k+1:2*k] == `LSD_SRC_PWM);
      wire       ofs_en  = (k < NOFS) ? I_SINK_OFFSET_ENABLE[k % NOFS] : 1'b0;
      wire       inv     = I_OFFSET_INVERT_ENABLE[k % 3];
      wire [7:0] ofs     = I_OFFSET_LEVEL[8*(k%3)+7:8*(k%3)];
      wire [7:0] lvl     = I_SINK_LEVEL[8*k+7:8*k];
      wire       gate    = pwm_sel ? O_PWM : 1'b1;
      wire       ginv    = ofs_en && inv ? ~gate : gate;
      always @(posedge I_CORE_CLK or negedge I_RESETN)
      begin
        if (!I_RESETN)
        begin
          O_SINK_ON[k]           <= 1'b0;
          O_SINK_DAC[8*k+7:8*k]  <= 8'h00;
        end
        else if (ofs_en)
        begin
          // Offset independent of source select
          O_SINK_ON[k] <= 1'b1;
          if (inv)
            O_SINK_DAC[8*k+7:8*k] <= ofs - 8'h01 - (ginv ? 8'h00 : lvl);
          else
            O_SINK_DAC[8*k+7:8*k] <= ofs + (ginv ? lvl : 8'h00);
        end
        else
        begin
          O_SINK_ON[k]          <= gate;
          O_SINK_DAC[8*k+7:8*k] <= lvl;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: lsd_dimmer_monitor.sv
// Checker for the dimmer top, attached by bind.
// Assumes TICK_DIV of 5 or more, so a PWM level holds for 4+ clocks.
`timescale 1ns/1ps
`default_nettype none
module lsd_dimmer_monitor
#(
  parameter integer NSINK = 7,
  parameter integer NOFS  = 6
)
(
  input wire logic [0:0]         I_CORE_CLK,
  input wire logic               I_RESETN,
  input wire logic               I_DUTY_WRITE,
  input wire logic [7:0]         I_DUTY_WDATA,
  input wire logic [1:0]         I_RAMP_DIR,
  input wire logic [2*NSINK-1:0] I_SINK_SOURCE_SEL,
  input wire logic [NOFS-1:0]    I_SINK_OFFSET_ENABLE,
  input wire logic [7:0]         O_DUTY_CODE,
  input wire logic               O_PWM,
  input wire logic [1:0]         O_ANALOG_DIV,
  input wire logic [NSINK-1:0]   O_SINK_ON
);
  // Divider implied by the live code; 11 direction is a hold too
  wire [1:0] exp_div = O_DUTY_CODE[7] ? 2'h0 : (O_DUTY_CODE[6] ? 2'h1 : 2'h2);
  wire       hold    = I_RAMP_DIR[0] == I_RAMP_DIR[1];
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);
  //////////////////////////////////////////////////////////////////
  chk_write_loads: assert property (I_DUTY_WRITE |=> O_DUTY_CODE == $past(I_DUTY_WDATA))
    else $error("duty load");
  chk_hold_still: assert property (!I_DUTY_WRITE && hold |=> $stable(O_DUTY_CODE))
    else $error("duty moved");
  chk_up_mono: assert property (I_RAMP_DIR == 2'h1 && !I_DUTY_WRITE |=> O_DUTY_CODE >= $past(O_DUTY_CODE))
    else $error("up fell");
  chk_down_mono: assert property (I_RAMP_DIR == 2'h2 && !I_DUTY_WRITE |=> O_DUTY_CODE <= $past(O_DUTY_CODE))
    else $error("down rose");
  chk_div_map: assert property ($changed(O_DUTY_CODE) |-> ##[1:300] O_ANALOG_DIV == exp_div)
    else $error("divider");
  chk_pwm_stands: assert property ($rose(O_PWM) |=> O_PWM [*3])
    else $error("pwm glitch");
  chk_sink_gate: assert property (I_SINK_SOURCE_SEL[2*NSINK-1 -: 2] == 2'h2 |=> O_SINK_ON[NSINK-1] == $past(O_PWM))
    else $error("sink gate");
  chk_offset_on: assert property (I_SINK_OFFSET_ENABLE[0] |=> O_SINK_ON[0])
    else $error("offset sink");
endmodule
bind lsd_dimmer lsd_dimmer_monitor #(.NSINK(NSINK), .NOFS(NOFS)) u_lsd_dimmer_monitor (.I_CORE_CLK,
  .I_RESETN, .I_DUTY_WRITE, .I_DUTY_WDATA, .I_RAMP_DIR, .I_SINK_SOURCE_SEL, .I_SINK_OFFSET_ENABLE,
  .O_DUTY_CODE, .O_PWM, .O_ANALOG_DIV, .O_SINK_ON);
`default_nettype wire

// File: lsd_dimmer_tb.sv
// Bench for the dimmer top, ramp included, through its own ports.
// Assumes short TICK_DIV and shortened ramp intervals to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module lsd_dimmer_tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  wd = 8'h00;
  logic [1:0]  dir = 2'h0;
  logic [2:0]  spd = 3'h0;
  logic [13:0] sel = 14'h0000;
  logic [5:0]  ofs_en = 6'h00;
  logic [2:0]  inv = 3'h0;
  wire  [7:0]  duty;
  wire         pwm;
  wire  [1:0]  div;
  wire  [6:0]  sink_on;
  wire  [55:0] dac;
  int          errors = 0, num_checks = 0, c, st, k;
  lsd_dimmer #(.TICK_DIV(5), .RAMP_TPU(1), .RAMP_DIV(100)) u_lsd_dimmer (.I_CORE_CLK(clk),
    .I_RESETN(rstn), .I_DUTY_WRITE(wr),
    .I_DUTY_WDATA(wd), .I_RAMP_DIR(dir), .I_RAMP_SPEED(spd), .I_SINK_SOURCE_SEL(sel),
    // Level 10h with offset 20h: sum within 255, offset-level-1 not negative
    .I_SINK_LEVEL({7{8'h10}}), .I_SINK_OFFSET_ENABLE(ofs_en),
    .I_OFFSET_LEVEL({3{8'h20}}),
    .I_OFFSET_INVERT_ENABLE(inv), .O_DUTY_CODE(duty), .O_PWM(pwm), .O_ANALOG_DIV(div),
    .O_SINK_ON(sink_on), .O_SINK_DAC(dac));
  always #2 clk = ~clk;
  //////////////////////////////////////////////////////////////////
  task chk(input logic [63:0] got, input logic [63:0] exp, input string nm);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // One-clock write pulse, inputs moved on the falling edge
  task put(input logic [7:0] v);
    @(negedge clk);
    wr = 1'b1;
    wd = v;
    @(negedge clk);
    wr = 1'b0;
    chk(duty, v, "duty");
  endtask
  // Step sizes worked out here; waits bounded since phase drifts per write
  task ramp(input logic [7:0] s, input logic [1:0] d, input logic [2:0] sp, input int n);
    put(s);
    spd = sp;
    dir = d;
    c = s;
    repeat (n)
    begin
      st = sp[0] ? c / 8 : c / 4;
      st = (st == 0) ? 1 : st;
      k = c;
      c = d[0] ? ((c + st > 255) ? 255 : c + st) : ((c < st) ? 0 : c - st);
      for (int j = 0; j < 3000 && duty === k[7:0]; j++)
        @(negedge clk);
      chk(duty, c[7:0], "step");
    end
    repeat ((c == 0 || c == 255) ? 2600 : 0) @(negedge clk);
    chk(duty, c[7:0], "ramp end");
    dir = 2'h0;
  endtask
  task give_verdict;
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  // Hang guard, well past the expected run length
  initial
  begin
    #(30000 * 4);
    errors++;
    give_verdict;
  end
  // Code regions, then offset path, then ramps
  initial
  begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      put(i == 0 ? 8'h80 : (i == 1 ? 8'h7E : 8'h05));
      repeat (400) @(negedge clk);
      chk(div, i, "divider");
      k = 0;
      repeat (320)
      begin
        @(negedge clk);
        k += (pwm === 1'b1);
      end
      chk(k, (i == 0 ? 32 : (i == 1 ? 63 : 5)) * 5, "pwm on");
    end
    sel = 14'h2002;
    ofs_en = 6'h01;
    put(8'h00);
    repeat (400) @(negedge clk);
    chk(sink_on, 7'h3F, "sink on");
    chk(dac[7:0], 8'h20, "offset dac");
    inv = 3'h1;
    repeat (4) @(negedge clk);
    chk(dac[7:0], 8'h1F, "inverted dac");
    ofs_en = 6'h00;
    repeat (4) @(negedge clk);
    chk(dac[7:0], 8'h10, "offset off dac");
    ramp(8'hFF, 2'h2, 3'h6, 21);
    ramp(8'hFF, 2'h2, 3'h7, 1);
    ramp(8'h00, 2'h1, 3'h6, 2);
    ramp(8'hC0, 2'h1, 3'h6, 2);
    give_verdict;
  end
endmodule
`default_nettype wire

// File: lsd_ramp.v
// Duty-code store with automatic logarithmic up/down ramp.
// Assumes a one-cycle tick strobe at the modulator clock rate.
`timescale 1ns/1ps
`default_nettype none
`include "lsd_defs.vh"
module lsd_ramp
#(
  parameter integer TICKS_PER_US = `LSD_TICKS_PER_US,
  // Interval divisor; 1 gives the real step times, larger only shortens test runs
  parameter integer INTERVAL_DIV = 1
)
(
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_resetn,
  // Control
  input  wire       i_tick,
  input  wire       i_write,
  input  wire [7:0] i_wdata,
  input  wire [1:0] i_dir,
  input  wire [2:0] i_speed,
  // Status
  output reg  [7:0] o_duty
);
  localparam [31:0] T50  = `LSD_STEP_50MS_US * TICKS_PER_US / INTERVAL_DIV;
  localparam [31:0] T25  = `LSD_STEP_25MS_US * TICKS_PER_US / INTERVAL_DIV;
  localparam [31:0] T5   = `LSD_STEP_5MS_US * TICKS_PER_US / INTERVAL_DIV;
  localparam [31:0] T2P5 = `LSD_STEP_2P5MS_US * TICKS_PER_US / INTERVAL_DIV;

  reg  [17:0] cnt;
  reg  [17:0] limit;
  reg  [7:0]  delta;
  reg  [8:0]  sum;
  reg  [7:0]  next_duty;
  wire        ramping = (i_dir == `LSD_DIR_UP) || (i_dir == `LSD_DIR_DOWN);
  wire        step    = i_tick && ramping && (cnt == limit);

  // Interval per speed code; bit0 picks eighth steps
  always @*
  begin
    case (i_speed[2:1])
      2'h0:    limit = T50[17:0] - 18'h00001;
      2'h1:    limit = T25[17:0] - 18'h00001;
      2'h2:    limit = T5[17:0] - 18'h00001;
      default: limit = T2P5[17:0] - 18'h00001;
    endcase
    delta = i_speed[0] ? {3'h0, o_duty[7:3]} : {2'h0, o_duty[7:2]};
    if (delta == 8'h00)
      delta = 8'h01; // Minimum step so ramps finish
    sum = 9'h000;
    next_duty = o_duty;
    if (i_dir == `LSD_DIR_UP)
    begin
      sum = {1'b0, o_duty} + {1'b0, delta};
      next_duty = sum[8] ? `LSD_DUTY_MAX : sum[7:0];
    end
    else if (o_duty != 8'h00)
      next_duty = (o_duty > delta) ? o_duty - delta : 8'h00;
  end

  // Interval counter; cleared while holding so a new ramp starts fresh
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      cnt <= 18'h00000;
    else if (!ramping || i_write)
      cnt <= 18'h00000;
    else if (i_tick)
      cnt <= (cnt >= limit) ? 18'h00000 : cnt + 18'h00001;
  end

  // Software write beats a ramp step in the same cycle
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_duty <= `LSD_DUTY_RESET;
    else if (i_write)
      o_duty <= i_wdata;
    else if (step)
      o_duty <= next_duty;
  end
endmodule
`default_nettype wire
